/* File: pkg/lim_params.svh */
// Purpose: constants of the link interrupt mask and iso transmit events
// Assumes: 32-bit register bus, byte addresses as printed
// Notes: header holds definitions only
// Function
// (R1) overlong, inconsistent, lost cycle sources gate on mask and event
// (R2) fatal error source gates on mask and event both set
// (R3) 64 s rollover and cycle start sources gate on mask and event
// (R4) phy status and failed register access gate on mask and event
// (R5) serial bus reset source gates on mask and event
// (R6) both node id complete sources gate on mask and event
// (R7) mask bits 14 to 10 are reserved and read zero
// (R8) lock reply and posted write errors gate on mask and event
// (R9) iso receive and iso transmit summaries gate on mask and event
// (R10) received response and request packets gate on mask and event
// (R11) async receive response and request dma gate on mask and event
// (R12) response and request sent sources gate on mask and event
// (R13) context raises interrupt on final output command with bits 11
// (R14) rising context interrupt or write one at set address sets event
// (R15) only write one at clear address clears an event bit
// (R16) read at event clear address returns events and context mask
// (R17) event bits 31 to 8 reset and read zero
// (R18) transmit summary is unlatched or of events and context enables
// (R19) no interrupt leaves while global gate bit 31 is zero; code gates irq_out only, irq_src still passes
// (R20) both mask addresses read back the mask contents
// (R21) per context transmit mask with own set and clear addresses
// (R22) writing zero to any set or clear address changes nothing
`ifndef LIM_PARAMS_SVH
`define LIM_PARAMS_SVH
`define LIM_AW             8
`define LIM_DW             32
`define LIM_NCTX           8
`define LIM_OFS_MASK_SET   8'h88
`define LIM_OFS_MASK_CLR   8'h8C
`define LIM_OFS_TXEV_SET   8'h90
`define LIM_OFS_TXEV_CLR   8'h94
`define LIM_OFS_TXMSK_SET  8'h98
`define LIM_OFS_TXMSK_CLR  8'h9C
`define LIM_MASK_RW        32'hEFFF_83FF
`define LIM_MASK_RST       32'h0000_0000
`define LIM_CTX_RST        8'h00
`define LIM_BIT_GLOBAL     31
`define LIM_BIT_TX_SUM     6
`define LIM_INT_ALWAYS     2'h3
`define LIM_RESP_OKAY      2'h0
`define LIM_RESP_SLVERR    2'h2
`define LIM_ZERO32         32'h0000_0000
`endif

/* File: pkg/lim_pkg.sv */
// Purpose: state types of the link interrupt mask block
// Assumes: constants come from lim_params.svh
// Notes: each module keeps all its state in one packed struct
`include "lim_params.svh"
package lim_pkg;

  typedef struct packed {
    logic                  aw_got;
    logic                  w_got;
    logic [`LIM_AW-1:0]    aw_addr;
    logic [`LIM_DW-1:0]    w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [`LIM_DW-1:0]    rdata;
    logic [1:0]            rresp;
    logic [`LIM_DW-1:0]    mask;
    logic [`LIM_DW-2:0]    gated;
    logic                  irq;
  } lim_main_st_t;

  typedef struct packed {
    logic [`LIM_NCTX-1:0]  evt;
    logic [`LIM_NCTX-1:0]  msk;
    logic [`LIM_NCTX-1:0]  lvl;
  } lim_ctx_st_t;

endpackage

/* File: test/lim_irq_assertions.sv */
// Purpose: port-level checks of lim_irq_top
// Assumes: only top ports visible, read address captured here
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module lim_chk
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // interrupt side
  input wire logic [31:0] main_event,
  input wire logic        irq_out,
  input wire logic [30:0] irq_src,
  input wire logic        iso_transmit_summary
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address of the read in flight, needed to judge its data
  logic [7:0] ra;
  always_ff @(posedge aclk)
    if (arvalid && arready)
      ra <= araddr;
  sequence s_take;
    arvalid && arready;
  endsequence
  sequence s_wait;
    rvalid && !rready;
  endsequence
  property p_rd_ans;
    s_take |=> rvalid;
  endproperty
  property p_rd_hold;
    s_wait |=> rvalid && $stable(rdata);
  endproperty
  property p_ar_busy;
    rvalid |-> !arready;
  endproperty
  property p_wr_hold;
    bvalid && !bready |=> bvalid;
  endproperty
  property p_src_rsvd;
    irq_src[14:10] == 5'h00 && !irq_src[28];
  endproperty
  property p_gate;
    (irq_src & ~$past(main_event[30:0]) & 31'h7FFF_FFBF) == 31'h0000_0000;
  endproperty
  property p_tx_src;
    irq_src[6] |-> $past(iso_transmit_summary);
  endproperty
  // both registered from the same cycle, so no lag between them
  property p_irq;
    irq_out |-> (|irq_src);
  endproperty
  property p_rd_data;
    $changed(rdata) |-> $rose(rvalid);
  endproperty
  property p_rd_done;
    rvalid && rready |=> !rvalid;
  endproperty
  property p_wr_done;
    bvalid && bready |=> !bvalid;
  endproperty
  property p_tx_rd;
    rvalid && ra[7:4] == 4'h9 |-> rdata[31:8] == 24'h00_0000;
  endproperty
  property p_mask_rd;
    rvalid && ra[7:3] == 5'h11 |-> rdata[14:10] == 5'h00;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  a_src_rsvd: assert property (p_src_rsvd) else $error("reserved src");
  a_gate: assert property (p_gate) else $error("src without event");
  a_tx_src: assert property (p_tx_src) else $error("tx src bad");
  a_irq: assert property (p_irq) else $error("irq without src");
  a_tx_rd: assert property (p_tx_rd) else $error("tx upper bits");
  a_mask_rd: assert property (p_mask_rd) else $error("mask rsvd read");
  a_rd_data: assert property (p_rd_data) else $error("read data moved");
  a_rd_done: assert property (p_rd_done) else $error("read answered twice");
  a_wr_done: assert property (p_wr_done) else $error("write answered twice");
endmodule
bind lim_irq_top lim_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .main_event(main_event), .irq_out(irq_out), .irq_src(irq_src),
  .iso_transmit_summary(iso_transmit_summary));
`default_nettype wire

/* File: test/tb_lim_irq_top.sv */
// Purpose: register-level bench of lim_irq_top
// Assumes: axi4-lite master tasks, events driven as levels
// Notes: outputs read right after an edge hold last cycle values
`timescale 1ns/1ps
`default_nettype none
module tb_lim_irq_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, awready, wready;
  logic        arvalid, rready, arready, rvalid, bvalid, irq_out, txs;
  logic [7:0]  awaddr, araddr, ctx_last_done;
  logic [31:0] wdata, rdata, main_event;
  logic [1:0]  bresp, rresp;
  logic [15:0] ctx_int_ctrl;
  logic [30:0] irq_src;
  int          err_total, n_checks, cyc, k;
  lim_irq_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .main_event(main_event),
    .ctx_last_done(ctx_last_done), .ctx_int_ctrl(ctx_int_ctrl),
    .irq_out(irq_out), .irq_src(irq_src), .iso_transmit_summary(txs));
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!w && wready)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      if (!aw && awready)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
    end
    // bready stays high; lowering it here would double-drive on a next call
    do @(posedge aclk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // whole run is under two hundred cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, ctx_last_done, wdata, main_event} = 88'h0;
    ctx_int_ctrl = 16'hF3FF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h88, 32'h0000_0000, 2'h0);
    rd(8'h90, 32'h0000_0000, 2'h0);
    wr(8'h88, 32'hFFFF_FFFF, 2'h0);
    rd(8'h8C, 32'hEFFF_83FF, 2'h0);
    wr(8'h8C, 32'h0000_0000, 2'h0);
    rd(8'h88, 32'hEFFF_83FF, 2'h0);
    for (k = 0; k < 31; k++)
    begin
      main_event <= 32'h0000_0001 << k;
      repeat (3) @(posedge aclk);
      chk({1'b0, irq_src}, (32'h1 << k) & 32'h6FFF_83BF);
      chk({31'h0, irq_out}, {31'h0, |((32'h1 << k) & 32'h6FFF_83BF)});
    end
    main_event <= 32'hFFFF_FFFF;
    wr(8'h8C, 32'h5555_5555, 2'h0);
    repeat (3) @(posedge aclk);
    chk({1'b0, irq_src}, 32'h2AAA_82AA);
    wr(8'h8C, 32'h8000_0000, 2'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq_out}, 32'h0000_0000);
    // context 3 enabled, context 5 has its control bits clear
    ctx_last_done <= 8'h28;
    repeat (3) @(posedge aclk);
    rd(8'h90, 32'h0000_0008, 2'h0);
    rd(8'h94, 32'h0000_0000, 2'h0);
    wr(8'h98, 32'h0000_00FF, 2'h0);
    wr(8'h88, 32'h0000_0040, 2'h0);
    rd(8'h94, 32'h0000_0008, 2'h0);
    chk({31'h0, txs}, 32'h0000_0001);
    chk({1'b0, irq_src} & 32'h0000_0040, 32'h0000_0040);
    wr(8'h94, 32'h0000_0008, 2'h0);
    repeat (3) @(posedge aclk);
    rd(8'h90, 32'h0000_0000, 2'h0);
    chk({31'h0, txs}, 32'h0000_0000);
    wr(8'h90, 32'hFFFF_FFF0, 2'h0);
    wr(8'h94, 32'h0000_0000, 2'h0);
    rd(8'h90, 32'h0000_00F0, 2'h0);
    wr(8'h9C, 32'h0000_00FF, 2'h0);
    rd(8'h98, 32'h0000_0000, 2'h0);
    rd(8'h94, 32'h0000_0000, 2'h0);
    wr(8'h40, 32'hFFFF_FFFF, 2'h2);
    rd(8'h40, 32'h0000_0000, 2'h2);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: verilog/lim_ctx_events.sv */
// Purpose: per-context iso transmit event and enable bits
// Assumes: set and clear strobes are one-cycle, already byte masked
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
`include "lim_params.svh"
module lim_ctx_events
  import lim_pkg::*;
(
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // context interrupt levels
  input  wire logic [`LIM_NCTX-1:0] ctx_irq_lvl,
  // software strobes
  input  wire logic [`LIM_NCTX-1:0] evt_set,
  input  wire logic [`LIM_NCTX-1:0] evt_clr,
  input  wire logic [`LIM_NCTX-1:0] msk_set,
  input  wire logic [`LIM_NCTX-1:0] msk_clr,
  // state seen by software
  output logic      [`LIM_NCTX-1:0] evt,
  output logic      [`LIM_NCTX-1:0] msk,
  output logic                      summary
);

  lim_ctx_st_t              s;
  lim_ctx_st_t              next_s;
  logic [`LIM_NCTX-1:0]     next_evt;
  logic [`LIM_NCTX-1:0]     next_msk;

  genvar i;
  for (i = 0; i < `LIM_NCTX; i++)
  begin : g_ctx
    // only a rising level edge or a set strobe sets; a held level cannot re-set after a clear
    assign next_evt[i] = (ctx_irq_lvl[i] & ~s.lvl[i]) | evt_set[i] // R14
                       | (s.evt[i] & ~evt_clr[i]); // R15
    assign next_msk[i] = msk_set[i] | (s.msk[i] & ~msk_clr[i]); // R21
  end

  always_comb
  begin
    next_s     = s;
    next_s.evt = next_evt;
    next_s.msk = next_msk;
    next_s.lvl = ctx_irq_lvl;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s.evt <= `LIM_CTX_RST; // R17
      s.msk <= `LIM_CTX_RST;
      s.lvl <= `LIM_CTX_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign evt     = s.evt;
  assign msk     = s.msk;
  assign summary = |(s.evt & s.msk); // R18

endmodule
`default_nettype wire

/* File: verilog/lim_irq_top.sv */
// Purpose: interrupt enable mask and iso transmit context events
// Assumes: main event bits arrive as levels from the event register
// Notes: axi4-lite slave, one write and one read in flight at a time
`timescale 1ns/1ps
`default_nettype none
`include "lim_params.svh"
module lim_irq_top
  import lim_pkg::*;
(
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [`LIM_AW-1:0]      awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  // axi4-lite write data
  input  wire logic [`LIM_DW-1:0]      wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // axi4-lite write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read address
  input  wire logic [`LIM_AW-1:0]      araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  // axi4-lite read data
  output logic [`LIM_DW-1:0]           rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // main event register levels, bit 6 is formed here
  input  wire logic [`LIM_DW-1:0]      main_event,
  // iso transmit contexts
  input  wire logic [`LIM_NCTX-1:0]    ctx_last_done,
  input  wire logic [2*`LIM_NCTX-1:0]  ctx_int_ctrl,
  // interrupt outputs
  output logic                         irq_out,
  output logic [`LIM_DW-2:0]           irq_src,
  output logic                         iso_transmit_summary
);

  lim_main_st_t              s;
  lim_main_st_t              next_s;

  logic [`LIM_DW-1:0]        byte_mask;
  logic [`LIM_DW-1:0]        wr_ones;
  logic [`LIM_AW-1:0]        wr_addr;
  logic [`LIM_AW-1:0]        rd_addr;
  logic                      wr_fire;
  logic                      rd_fire;
  logic                      wr_hit;
  logic [`LIM_DW-1:0]        evt_vec;
  logic [`LIM_DW-1:0]        en_vec;
  logic [`LIM_DW-2:0]        gated_now;
  logic [`LIM_NCTX-1:0]      ctx_irq_lvl;
  logic [`LIM_NCTX-1:0]      tx_evt;
  logic [`LIM_NCTX-1:0]      tx_msk;
  logic [`LIM_NCTX-1:0]      tx_evt_set;
  logic [`LIM_NCTX-1:0]      tx_evt_clr;
  logic [`LIM_NCTX-1:0]      tx_msk_set;
  logic [`LIM_NCTX-1:0]      tx_msk_clr;
  logic                      tx_summary;

  // bus handshakes

  // a new address or data beat waits while a response is still pending
  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready  = ~s.w_got & ~s.bvalid;
  assign arready = ~s.rvalid;
  assign wr_fire = s.aw_got & s.w_got & ~s.bvalid;
  assign rd_fire = arvalid & arready;

  // word aligned addresses; low two bits do not select
  assign wr_addr = {s.aw_addr[`LIM_AW-1:2], 2'h0};
  assign rd_addr = {araddr[`LIM_AW-1:2], 2'h0};

  // write strobes turn whole bytes on or off
  genvar b;
  for (b = 0; b < 4; b++)
  begin : g_strb
    assign byte_mask[8*b +: 8] = {8{s.w_strb[b]}};
  end

  // zero bits of a set or clear write are simply not acted on
  assign wr_ones = wr_fire ? (s.w_data & byte_mask) : `LIM_ZERO32; // R22

  // context interrupt: final output command finished, control bits 11
  genvar c;
  for (c = 0; c < `LIM_NCTX; c++)
  begin : g_ctx_lvl
    assign ctx_irq_lvl[c] = ctx_last_done[c]
                          & (ctx_int_ctrl[2*c +: 2] == `LIM_INT_ALWAYS); // R13
  end

  // iso transmit strobes; bits 31 to 8 of the data are ignored
  always_comb
  begin
    tx_evt_set = `LIM_CTX_RST;
    tx_evt_clr = `LIM_CTX_RST;
    tx_msk_set = `LIM_CTX_RST;
    tx_msk_clr = `LIM_CTX_RST;
    case (wr_addr)
      `LIM_OFS_TXEV_SET:
      begin
        tx_evt_set = wr_ones[`LIM_NCTX-1:0]; // R14
      end
      `LIM_OFS_TXEV_CLR:
      begin
        tx_evt_clr = wr_ones[`LIM_NCTX-1:0]; // R15
      end
      `LIM_OFS_TXMSK_SET:
      begin
        tx_msk_set = wr_ones[`LIM_NCTX-1:0]; // R21
      end
      `LIM_OFS_TXMSK_CLR:
      begin
        tx_msk_clr = wr_ones[`LIM_NCTX-1:0]; // R21
      end
      default:
      begin
        tx_evt_set = `LIM_CTX_RST;
      end
    endcase
  end

  lim_ctx_events u_ctx_events (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ctx_irq_lvl (ctx_irq_lvl),
    .evt_set     (tx_evt_set),
    .evt_clr     (tx_evt_clr),
    .msk_set     (tx_msk_set),
    .msk_clr     (tx_msk_clr),
    .evt         (tx_evt),
    .msk         (tx_msk),
    .summary     (tx_summary)
  );

  // the transmit summary replaces whatever arrives on event bit 6
  always_comb
  begin
    evt_vec                  = main_event;
    evt_vec[`LIM_BIT_TX_SUM] = tx_summary; // R18
  end

  // reserved enables never take part, even if the level is high
  assign en_vec = s.mask & `LIM_MASK_RW; // R7

  // each source passes only with its enable and its event both 1
  genvar k;
  for (k = 0; k < `LIM_DW - 1; k++)
  begin : g_gate
    assign gated_now[k] = en_vec[k] & evt_vec[k]; // R1 R2 R3 R4 R5 R6
  end
  // R8 R9 R10 R11 R12 share the gating above

  assign wr_hit = (wr_addr == `LIM_OFS_MASK_SET)
                | (wr_addr == `LIM_OFS_MASK_CLR)
                | (wr_addr == `LIM_OFS_TXEV_SET)
                | (wr_addr == `LIM_OFS_TXEV_CLR)
                | (wr_addr == `LIM_OFS_TXMSK_SET)
                | (wr_addr == `LIM_OFS_TXMSK_CLR);

  always_comb
  begin
    next_s = s;

    // capture address and data in either order
    if (awvalid & awready)
    begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid & wready)
    begin
      next_s.w_got  = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end

    // perform the write once both halves are held
    if (wr_fire)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = wr_hit ? `LIM_RESP_OKAY : `LIM_RESP_SLVERR;
      if (wr_addr == `LIM_OFS_MASK_SET)
      begin
        next_s.mask = s.mask | (wr_ones & `LIM_MASK_RW); // R22
      end
      else if (wr_addr == `LIM_OFS_MASK_CLR)
      begin
        next_s.mask = s.mask & ~(wr_ones & `LIM_MASK_RW); // R22
      end
    end
    else if (s.bvalid & bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // read answer is registered, one cycle after the address
    if (rd_fire)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `LIM_RESP_OKAY;
      case (rd_addr)
        `LIM_OFS_MASK_SET,
        `LIM_OFS_MASK_CLR:
        begin
          next_s.rdata = en_vec; // R20 R7
        end
        `LIM_OFS_TXEV_SET:
        begin
          next_s.rdata = {{(`LIM_DW-`LIM_NCTX){1'b0}}, tx_evt}; // R17
        end
        `LIM_OFS_TXEV_CLR:
        begin
          next_s.rdata = {{(`LIM_DW-`LIM_NCTX){1'b0}},
                          tx_evt & tx_msk}; // R16
        end
        `LIM_OFS_TXMSK_SET,
        `LIM_OFS_TXMSK_CLR:
        begin
          next_s.rdata = {{(`LIM_DW-`LIM_NCTX){1'b0}}, tx_msk}; // R21
        end
        default:
        begin
          next_s.rdata = `LIM_ZERO32;
          next_s.rresp = `LIM_RESP_SLVERR;
        end
      endcase
    end
    else if (s.rvalid & rready)
    begin
      next_s.rvalid = 1'b0;
    end

    // registered outputs; the global gate holds back irq_out, not irq_src
    next_s.gated = gated_now;
    next_s.irq   = en_vec[`LIM_BIT_GLOBAL] & (|gated_now); // R19
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s.aw_got  <= 1'b0;
      s.w_got   <= 1'b0;
      s.aw_addr <= '0;
      s.w_data  <= `LIM_ZERO32;
      s.w_strb  <= 4'h0;
      s.bvalid  <= 1'b0;
      s.bresp   <= `LIM_RESP_OKAY;
      s.rvalid  <= 1'b0;
      s.rdata   <= `LIM_ZERO32;
      s.rresp   <= `LIM_RESP_OKAY;
      s.mask    <= `LIM_MASK_RST;
      s.gated   <= '0;
      s.irq     <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs
  assign bvalid               = s.bvalid;
  assign bresp                = s.bresp;
  assign rvalid               = s.rvalid;
  assign rdata                = s.rdata;
  assign rresp                = s.rresp;
  assign irq_out              = s.irq;
  assign irq_src              = s.gated;
  // unlatched by intent: follows events and enables directly
  assign iso_transmit_summary = tx_summary;

endmodule
`default_nettype wire
